// ### design/angle_serial_pwm_readout.sv
// Serial command/readout port and PWM output of the angle sensor.
// Assumes samples arrive from the sensor core on sys_clk with valid/ready,
// and that the serial clock, select, data and straps are asynchronous pins.
module angle_serial_pwm_readout (
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic                          serial_clk,
   input  wire logic                          chip_select,
   input  wire logic                          serial_data_i,
   output logic                               serial_data_o,
   output logic                               serial_data_oe,
   output logic                               derived_select_out,
   input  wire logic                          wire_count_select,
   input  wire logic                          test_mode_strap,
   input  angle_readout_pkg::sample_type      sample_in,
   input  wire logic                          sample_valid,
   output logic                               sample_ready,
   output logic                               pwm_out,
   output angle_readout_pkg::power_type       power_mode,
   output logic                               hyst_disabled
);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   angle_readout_pkg::state_type q;
   angle_readout_pkg::state_type d;

   logic rise;
   logic fall;
   logic two_wire;
   logic sel_active;
   logic drain;

   assign rise     = q.sclk_sync[1] & ~q.sclk_sync[2];
   assign fall     = ~q.sclk_sync[1] & q.sclk_sync[2];
   assign two_wire = q.wire_sync[1];
   assign sel_active = two_wire ? (q.int_sel | rise) : q.cs_sync[1];
   assign drain    = (q.phase != angle_readout_pkg::PH_DATA) && (q.fifo_cnt != 2'd0);

   function automatic logic cmd_drives(input logic [4:0] c);
      cmd_drives = (c != angle_readout_pkg::CMD_WRITE_CONFIG);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      angle_readout_pkg::sample_type head;
      logic [4:0]  new_cmd;
      logic [7:0]  diff;
      logic        up;
      logic [8:0]  nphase;
      head    = q.fifo[0];
      new_cmd = {q.cmd[3:0], q.sdi_sync[1]};
      diff    = 8'h00;
      up      = 1'b0;
      nphase  = q.pwm_phase;
      d = q;

      d.sclk_sync = {q.sclk_sync[1:0], serial_clk};
      d.cs_sync   = {q.cs_sync[0], chip_select};
      d.sdi_sync  = {q.sdi_sync[0], serial_data_i};
      d.wire_sync = {q.wire_sync[0], wire_count_select};
      d.test_sync = {q.test_sync[0], test_mode_strap};

      // Internal select of the two-wire mode.
      if (two_wire) begin
         if (rise) begin
            d.int_sel = 1'b1;
            d.to_cnt  = 10'h000;
         end else if (q.int_sel) begin
            d.to_cnt = q.to_cnt + 10'h001;
            if (q.to_cnt == 10'(angle_readout_pkg::TIMEOUT_CYCLES - 1)) begin
               d.int_sel = 1'b0;
            end
         end
      end else begin
         d.int_sel = 1'b0;
         d.to_cnt  = 10'h000;
      end

      // Serial frame engine.
      if (!sel_active || (two_wire && !d.int_sel) || q.test_sync[1]) begin
         d.phase   = angle_readout_pkg::PH_CMD;
         d.bit_cnt = 5'h00;
         d.oe      = 1'b0;
      end else if (rise) begin
         if (q.phase == angle_readout_pkg::PH_CMD) begin
            d.cmd     = new_cmd;
            d.bit_cnt = q.bit_cnt + 5'h01;
            if (q.bit_cnt == 5'(angle_readout_pkg::CMD_BITS - 1)) begin
               d.phase   = angle_readout_pkg::PH_DATA;
               d.bit_cnt = 5'h00;
               d.shift   = 16'h0000;
               if (new_cmd == angle_readout_pkg::CMD_READ_ANGLE) begin
                  d.shift[7:0] = q.rep_angle;
                  d.shift[angle_readout_pkg::PAY_VALID_POS] = q.rep_valid;
               end
            end
         end else begin
            d.wdata   = {q.wdata[14:0], q.sdi_sync[1]};
            d.bit_cnt = q.bit_cnt + 5'h01;
            if (q.bit_cnt == 5'(angle_readout_pkg::PAYLOAD_BITS - 1)) begin
               d.phase   = angle_readout_pkg::PH_CMD;
               d.bit_cnt = 5'h00;
               d.oe      = 1'b0;
               case (q.cmd)
                  angle_readout_pkg::CMD_LOW_POWER:  d.power = angle_readout_pkg::PWR_LOW;
                  angle_readout_pkg::CMD_POWER_DOWN: d.power = angle_readout_pkg::PWR_DOWN;
                  angle_readout_pkg::CMD_WAKE_UP:    d.power = angle_readout_pkg::PWR_NORMAL;
                  angle_readout_pkg::CMD_WRITE_CONFIG: begin
                     d.hyst_dis = d.wdata[angle_readout_pkg::CFG_HYST_DIS_POS];
                  end
                  default: d.power = q.power;
               endcase
            end
         end
      end else if (fall && q.phase == angle_readout_pkg::PH_DATA) begin
         // The falling edge sits half a serial clock after the rising one.
         if (q.bit_cnt == 5'h00) begin
            d.oe = cmd_drives(q.cmd);
         end else begin
            d.shift = {q.shift[14:0], 1'b0};
         end
      end

      // Two-entry sample buffer; the drain stalls during a data phase.
      if (drain) begin
         d.fifo[0] = q.fifo[1];
      end
      if (sample_valid && q.fifo_cnt != 2'd2) begin
         if (drain) begin
            d.fifo[q.fifo_cnt - 2'd1] = sample_in;
         end else begin
            d.fifo[q.fifo_cnt[0]] = sample_in;
         end
      end
      d.fifo_cnt = q.fifo_cnt + 2'((sample_valid && q.fifo_cnt != 2'd2) ? 1 : 0)
                   - 2'(drain ? 1 : 0);

      // Reported angle with direction hysteresis.
      if (drain) begin
         diff = head.angle - q.rep_angle;
         up   = ~diff[7];
         if (!head.valid) begin
            d.rep_valid = 1'b0;
         end else if (!q.rep_valid || q.hyst_dis) begin
            d.rep_valid = 1'b1;
            d.rep_angle = head.angle;
         end else if (diff != 8'h00) begin
            if (up == q.dir_up) begin
               d.rep_angle = head.angle;
            end else if (diff != 8'h01 && diff != 8'hff) begin
               d.rep_angle = head.angle;
               d.dir_up    = up;
            end
         end
      end

      // PWM generator.
      if (q.pwm_div == 7'(angle_readout_pkg::PWM_LSB_CYCLES - 1)) begin
         d.pwm_div = 7'h00;
         nphase = q.pwm_phase + 9'h001;
         if (q.pwm_phase == 9'(angle_readout_pkg::PWM_PERIOD_LSB - 1)) begin
            nphase      = 9'h000;
            d.pwm_angle = q.rep_angle;
            d.pwm_valid = q.rep_valid;
         end
         d.pwm_phase = nphase;
         d.pwm_out   = d.pwm_valid && (nphase <= {1'b0, d.pwm_angle});
      end else begin
         d.pwm_div = q.pwm_div + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q           <= '0;
         q.rep_angle <= angle_readout_pkg::ANGLE_RESET;
         q.power     <= angle_readout_pkg::PWR_NORMAL;
         q.phase     <= angle_readout_pkg::PH_CMD;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // In four-wire mode the raw select gates the enable so the line floats within 30 ns,
   // which the synchroniser latency could not meet.
   assign serial_data_oe     = q.oe & (two_wire | chip_select);
   assign serial_data_o      = q.shift[15];
   assign derived_select_out = q.int_sel;
   assign sample_ready       = (q.fifo_cnt != 2'd2);
   assign pwm_out            = q.pwm_out;
   assign power_mode         = q.power;
   assign hyst_disabled      = q.hyst_dis;

endmodule // angle_serial_pwm_readout

// ### design/angle_readout_pkg.sv
// Constants and carrier types of the angle serial and PWM readout.
// Assumes a single 40 MHz system clock.
package angle_readout_pkg;

   localparam int SYS_CLK_MHZ = 40;

   // Serial frame layout.
   localparam int CMD_BITS     = 5;
   localparam int PAYLOAD_BITS = 16;
   localparam int FRAME_BITS   = CMD_BITS + PAYLOAD_BITS;

   // Two-wire clock timeout, least time rounded up to cycles.
   localparam int TIMEOUT_NS     = 20000;
   localparam int TIMEOUT_CYCLES = (TIMEOUT_NS * SYS_CLK_MHZ + 999) / 1000;

   // One PWM step at its nominal length, and the period in steps.
   localparam int PWM_LSB_NS     = 2260;
   localparam int PWM_LSB_CYCLES = (PWM_LSB_NS * SYS_CLK_MHZ) / 1000;
   localparam int PWM_PERIOD_LSB = 257;

   // Command codes.
   localparam logic [4:0] CMD_READ_ANGLE   = 5'h00;
   localparam logic [4:0] CMD_LOW_POWER    = 5'h10;
   localparam logic [4:0] CMD_POWER_DOWN   = 5'h11;
   localparam logic [4:0] CMD_WAKE_UP      = 5'h12;
   localparam logic [4:0] CMD_WRITE_CONFIG = 5'h17;

   // Payload fields.
   localparam int PAY_VALID_POS   = 8;
   localparam int CFG_HYST_DIS_POS = 0;

   // Reset values.
   localparam logic [7:0] ANGLE_RESET = 8'h00;

   typedef enum logic [1:0] {
      PWR_NORMAL = 2'b00,
      PWR_LOW    = 2'b01,
      PWR_DOWN   = 2'b10
   } power_type;

   typedef enum logic [0:0] {
      PH_CMD  = 1'b0,
      PH_DATA = 1'b1
   } phase_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] angle;
   } sample_type;

   typedef struct packed {
      logic [2:0]       sclk_sync;
      logic [1:0]       cs_sync;
      logic [1:0]       sdi_sync;
      logic [1:0]       wire_sync;
      logic [1:0]       test_sync;
      phase_type        phase;
      logic [4:0]       bit_cnt;
      logic [4:0]       cmd;
      logic [15:0]      shift;
      logic [15:0]      wdata;
      logic             oe;
      logic             int_sel;
      logic [9:0]       to_cnt;
      sample_type [1:0] fifo;
      logic [1:0]       fifo_cnt;
      logic [7:0]       rep_angle;
      logic             rep_valid;
      logic             dir_up;
      logic             hyst_dis;
      power_type        power;
      logic [6:0]       pwm_div;
      logic [8:0]       pwm_phase;
      logic [7:0]       pwm_angle;
      logic             pwm_valid;
      logic             pwm_out;
   } state_type;

endpackage

// ### bench/angle_serial_pwm_readout_sva.sv
// Timing checks on the readout block's serial, select and PWM pins.
// Assumes the 40 MHz sys_clk and active high rst of the block.
module angle_serial_pwm_readout_sva (
   input wire logic                     sys_clk,
   input wire logic                     rst,
   input wire logic                     serial_clk,
   input wire logic                     chip_select,
   input wire logic                     serial_data_oe,
   input wire logic                     derived_select_out,
   input wire logic                     wire_count_select,
   input wire logic                     test_mode_strap,
   input wire logic                     pwm_out,
   input angle_readout_pkg::power_type  power_mode,
   input wire logic                     hyst_disabled
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic        sclk_q;
   logic [11:0] idle_q;
   logic [15:0] hi_q;
   // Cycles since the last serial clock rise, and length of the current PWM high run.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         idle_q <= '0;
         hi_q   <= '0;
      end else begin
         sclk_q <= serial_clk;
         idle_q <= (serial_clk && !sclk_q) ? '0 : idle_q + 12'(idle_q != 12'hfff);
         hi_q   <= pwm_out ? hi_q + 16'h0001 : '0;
      end
   end
   property p_float; !wire_count_select && !chip_select |-> !serial_data_oe; endproperty
   a_float: assert property (p_float) else $error("data pin driven while deselected");
   property p_test; test_mode_strap [*4] |-> !serial_data_oe; endproperty
   a_test: assert property (p_test) else $error("data pin driven with test strap high");
   property p_drive; $rose(serial_data_oe) |-> !serial_clk && (chip_select || wire_count_select); endproperty
   a_drive: assert property (p_drive) else $error("data drive began off the falling clock");
   property p_hold; $rose(serial_data_oe) |-> serial_data_oe [*8]; endproperty
   a_hold: assert property (p_hold) else $error("data drive too short");
   property p_cmd; $changed(power_mode) || $changed(hyst_disabled) |-> serial_clk; endproperty
   a_cmd: assert property (p_cmd) else $error("setting changed away from a clock rise");
   property p_sel_to; $fell(derived_select_out) |-> idle_q >= 795 && idle_q <= 815; endproperty
   a_sel_to: assert property (p_sel_to) else $error("select timeout length wrong");
   property p_sel_on; $rose(derived_select_out) |-> idle_q < 8 && wire_count_select; endproperty
   a_sel_on: assert property (p_sel_on) else $error("select rose without a clock rise");
   property p_pwm; $fell(pwm_out) |-> hi_q % 90 == 0 && hi_q >= 90 && hi_q <= 23040; endproperty
   a_pwm: assert property (p_pwm) else $error("PWM high time not whole steps");
endmodule // angle_serial_pwm_readout_sva
bind angle_serial_pwm_readout angle_serial_pwm_readout_sva u_sva (.*);

// ### bench/serial_master_model.sv
// Behavioural serial controller that clocks frames into the readout block.
// Assumes the bench resolves nothing else on the data pin.
module serial_master_model (
   output logic      sclk,
   output logic      cs,
   output logic      line,
   input  wire logic d_o,
   input  wire logic d_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mdat = 1'b0;
   logic mdrv = 1'b1;
   initial sclk = 1'b0;
   initial cs = 1'b0;
   // A pin nobody drives shows the inverse of the last bit sent.
   assign line = d_oe ? d_o : (mdrv ? mdat : ~mdat);
   task automatic frame(input logic [4:0] c, input logic [15:0] w, input int n, input logic s,
                        output logic [15:0] r);
      logic [20:0] f;
      f = {c, w};
      r = '0;
      mdrv = 1'b1;
      cs = s;
      #100;
      for (int i = 0; i < n; i++) begin
         mdat = f[20 - i];
         #250 sclk = 1'b1;
         if (i > 4) r = {r[14:0], line};
         #125 if (i == 4 && c != 5'h17) mdrv = 1'b0;
         #125 sclk = 1'b0;
      end
      #250 cs = 1'b0;
      mdrv = 1'b1;
   endtask
endmodule // serial_master_model

// ### bench/angle_serial_pwm_readout_tb_top.sv
// Self-checking bench for the angle serial and PWM readout block.
// Assumes serial_master_model as the controller on the serial pins.
module angle_serial_pwm_readout_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic wire_count_select = 1'b0;
   logic test_mode_strap = 1'b0;
   logic sample_valid = 1'b0;
   angle_readout_pkg::sample_type sample_in = '0;
   angle_readout_pkg::power_type pm;
   logic sclk, cs, line, d_o, d_oe, dsel, rdy, pwm, hd;
   logic [15:0] r;
   int n_fail = 0;
   int total_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   angle_serial_pwm_readout dut (.sys_clk(sys_clk), .rst(rst), .serial_clk(sclk), .chip_select(cs),
      .serial_data_i(line), .serial_data_o(d_o), .serial_data_oe(d_oe), .derived_select_out(dsel),
      .wire_count_select(wire_count_select), .test_mode_strap(test_mode_strap), .sample_in(sample_in),
      .sample_valid(sample_valid), .sample_ready(rdy), .pwm_out(pwm), .power_mode(pm), .hyst_disabled(hd));
   serial_master_model m (.sclk(sclk), .cs(cs), .line(line), .d_o(d_o), .d_oe(d_oe));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error at time %0t: saw %h, expected %h", $time, g, e);
      end
   endtask
   task complete_run;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task push(input logic v, input logic [7:0] a);
      int k;
      k = 0;
      sample_in = {v, a};
      sample_valid = 1'b1;
      @(posedge sys_clk);
      while (rdy !== 1'b1 && k < 50) begin
         k++;
         @(posedge sys_clk);
      end
      #2 sample_valid = 1'b0;
      if (k == 50) begin
         n_fail++;
         complete_run();
      end
      cyc(3);
   endtask
   task rd(input logic [15:0] e);
      m.frame(5'h00, 16'h0000, 21, !wire_count_select, r);
      chk(r, e);
   endtask
   // Counts sys_clk cycles with the PWM pin at level v, capped at one period and a little.
   task wt(input logic v, output int c);
      c = 0;
      while (pwm === v && c < 24000) begin
         c++;
         cyc(1);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_angle;
      push(1'b1, 8'h5a);
      rd(16'h015a);
      // A two-step jump is always taken and sets the direction to up.
      push(1'b1, 8'h5c);
      rd(16'h015c);
      // A one-step reversal against that direction must be held off.
      push(1'b1, 8'h5b);
      rd(16'h015c);
   endtask
   task t_config;
      m.frame(5'h17, 16'h0001, 21, 1'b1, r);
      cyc(5);
      chk({15'h0000, hd}, 16'h0001);
      push(1'b1, 8'h59);
      rd(16'h0159);
   endtask
   task t_power;
      for (int i = 0; i < 3; i++) begin
         m.frame(5'(5'h10 + i), 16'h0000, 21, 1'b1, r);
         cyc(5);
         chk({14'h0000, pm}, 16'((i + 1) % 3));
      end
   endtask
   task t_fill;
      int k;
      k = 0;
      fork
         m.frame(5'h00, 16'h0000, 21, 1'b1, r);
         begin
            while (d_oe !== 1'b1 && k < 400) begin
               k++;
               cyc(1);
            end
            if (k == 400) begin
               n_fail++;
               complete_run();
            end
            push(1'b1, 8'h20);
            push(1'b1, 8'h70);
            chk({15'h0000, rdy}, 16'h0000);
         end
      join
      chk(r, 16'h0159);
      cyc(5);
      chk({15'h0000, rdy}, 16'h0001);
      rd(16'h0170);
   endtask
   task t_pwm;
      int h, l;
      wt(1'b1, h);
      wt(1'b0, l);
      wt(1'b1, h);
      wt(1'b0, l);
      chk(h[15:0], 16'h27ba);
      chk(l[15:0], 16'h32a0);
      chk(16'((257 * h) / (h + l) - 1), 16'h0070);
      push(1'b0, 8'h70);
      wt(1'b1, h);
      wt(1'b0, l);
      chk(l[15:0], 16'h5dc0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(3);
      rst = 1'b0;
      cyc(4);
      t_angle();
      t_config();
      t_power();
      m.frame(5'h00, 16'h0000, 3, 1'b1, r);
      cyc(5);
      rd(16'h0159);
      t_fill();
      t_pwm();
      test_mode_strap = 1'b1;
      cyc(4);
      rd(16'hffff);
      test_mode_strap = 1'b0;
      wire_count_select = 1'b1;
      cyc(4);
      rd(16'h0070);
      chk({15'h0000, dsel}, 16'h0001);
      cyc(900);
      chk({15'h0000, dsel}, 16'h0000);
      complete_run();
   end
endmodule // angle_serial_pwm_readout_tb_top
